// *** ber_pkg.sv ***
// Notes on behaviour
// RULE1 - read completion data error: detected flag, parity flag
// RULE2 - error message with enable sets system error
// RULE3 - posted master abort system error, mask or mode
// RULE4 - write master abort sets detected; posted logs abort
// RULE5 - target abort sets detected and both abort flags
// RULE6 - unsupported completion sets primary master abort
// RULE7 - it sets signaled target abort only in mode
// RULE8 - completer abort sets received and signaled target abort
// RULE9 - unexpected completion logged unless masked; advisory correctable
// RULE10 - completion timeout logged unless masked; advisory correctable
// RULE11 - vendor message type zero is unsupported request
// RULE12 - non config, non message in low power unsupported
// RULE13 - type zero config to nonzero function unsupported
// RULE14 - unsupported request sets device flag; advisory correctable
// RULE15 - flags stay until write one; new error wins
package ber_pkg;
    // =========================================================
    // register byte offsets
    // =========================================================
    localparam logic [7:0] BER_OFF_CTRL = 8'h00; // control bits, read/write
    localparam logic [7:0] BER_OFF_PRI_STATUS = 8'h04; // primary status, write one to clear
    localparam logic [7:0] BER_OFF_SEC_STATUS = 8'h08; // secondary status, write one to clear
    localparam logic [7:0] BER_OFF_SEC_UNC_STATUS = 8'h0c; // secondary uncorrectable status
    localparam logic [7:0] BER_OFF_SEC_UNC_MASK = 8'h10; // secondary uncorrectable mask
    localparam logic [7:0] BER_OFF_UNC_STATUS = 8'h14; // uncorrectable status
    localparam logic [7:0] BER_OFF_UNC_MASK = 8'h18; // uncorrectable mask
    localparam logic [7:0] BER_OFF_UNC_SEVERITY = 8'h1c; // 1 = fatal per class
    localparam logic [7:0] BER_OFF_DEV_STATUS = 8'h20; // device status
    localparam logic [7:0] BER_OFF_INT_STATUS = 8'h24; // interrupt status, clear on read
    localparam logic [7:0] BER_OFF_INT_MASK = 8'h28; // interrupt enable, 1 = pass
    // =========================================================
    // control register fields
    // =========================================================
    localparam int BER_CTRL_SYSTEM_ERROR_REPORT_ENABLE = 0; // system_error_report_enable
    localparam int BER_CTRL_MA_MODE = 1; // master_abort_mode
    localparam int BER_CTRL_ADV_EN = 2; // advisory nonfatal handling enable
    localparam int BER_CTRL_PSTATE = 3; // power state, two bits
    localparam int BER_CTRL_SEC_FATAL = 5; // secondary class errors are fatal
    localparam int BER_CTRL_W = 6;
    localparam logic [5:0] BER_CTRL_RST = 6'h00;
    // =========================================================
    // status field positions
    // =========================================================
    localparam int BER_PRI_SSE = 0; // signaled_system_error
    localparam int BER_PRI_RMA = 1; // received_master_abort
    localparam int BER_PRI_RTA = 2; // received_target_abort
    localparam int BER_SEC_STA = 0; // signaled_target_abort
    localparam int BER_SEC_RTA = 1; // received_target_abort
    localparam int BER_SU_PERR = 0; // secondary_parity_error_flag
    localparam int BER_SU_RMA = 1; // received_master_abort
    localparam int BER_SU_RTA = 2; // received_target_abort
    localparam int BER_UN_UXC = 0; // unexpected_completion_flag
    localparam int BER_UN_CTO = 1; // completion_timeout_flag
    localparam int BER_UN_UR = 2; // unsupported request
    localparam int BER_DEV_COR = 0; // correctable_error_detected
    localparam int BER_DEV_NFTL = 1; // nonfatal_error_detected
    localparam int BER_DEV_FTL = 2; // fatal_error_detected
    localparam int BER_DEV_URD = 3; // unsupported_request_detected
    localparam int BER_INT_MSG = 0; // error message sent upstream
    localparam int BER_INT_COR = 1; // correctable error logged
    localparam int BER_INT_UR = 2; // unsupported request logged
    localparam int BER_W3 = 3; // width of three-bit groups
    localparam int BER_W4 = 4; // width of device status
    localparam logic [2:0] BER_MASK3_RST = 3'h0; // masks reset open, interrupt enables reset off
    localparam logic [2:0] BER_SEV_RST = 3'h0; // all classes nonfatal
    // =========================================================
    // power states
    // =========================================================
    typedef enum logic [1:0] {
        BER_D0 = 2'b00,
        BER_D1 = 2'b01,
        BER_D2 = 2'b10,
        BER_D3HOT = 2'b11
    } ber_pstate_e;
endpackage : ber_pkg

// *** ber_flags.sv ***
`timescale 1ns/10ps
// sticky flag group: set by hardware, cleared by software writing one
module ber_flags #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // set and clear vectors
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // flag state
    output logic [W-1:0] q
);
    // refuse an empty flag group at elaboration
    if (W < 1) begin : g_bad_width
        $error("ber_flags width must be positive");
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set; // RULE15
        end
    end
endmodule : ber_flags

// *** ber_ahb.sv ***
`timescale 1ns/10ps
// ahb-lite slave front end: writes take no wait, reads take one wait state
module ber_ahb (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    // register strobes
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] reg_addr
);
    logic ph_write; // data phase is a write
    logic ph_valid; // data phase is active
    logic rd_wait; // first read data cycle
    logic take; // address phase accepted

    // accept a nonseq or seq word transfer when the bus is ready
    assign take = hsel & htrans[1] & hready & (hsize == 3'h2);

    // latch address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            reg_addr <= 8'h00;
        end else if (hready) begin
            ph_valid <= take;
            ph_write <= hwrite;
            reg_addr <= {haddr[7:2], 2'b00};
        end
    end

    // one wait state on reads so read data is registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
        end else begin
            rd_wait <= take & ~hwrite;
        end
    end

    assign hreadyout = ~rd_wait;
    assign hresp = 1'b0;
    assign wr_en = ph_valid & ph_write;
    assign rd_en = rd_wait;
endmodule : ber_ahb

// *** ber_top.sv ***
`timescale 1ns/10ps
// error detection and status logging of the bridge
module ber_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite register port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // secondary bus events, one-cycle pulses
    input wire logic ev_read_cpl_data_err,
    input wire logic ev_posted_wr_master_abort,
    input wire logic ev_nonposted_wr_master_abort,
    input wire logic ev_posted_target_abort,
    input wire logic ev_nonposted_target_abort,
    // completion events, one-cycle pulses
    input wire logic ev_ur_completion,
    input wire logic ev_ca_completion,
    input wire logic ev_unexpected_completion,
    input wire logic ev_completion_timeout,
    // received request, qualified by req_valid
    input wire logic req_valid,
    input wire logic req_is_config,
    input wire logic req_is_message,
    input wire logic req_is_vendor_type0,
    input wire logic req_cfg_type0,
    input wire logic [2:0] req_function,
    // upstream error messages, one-cycle pulses
    output logic msg_fatal,
    output logic msg_nonfatal,
    output logic msg_correctable,
    // interrupt
    output logic irq
);
    // =========================================================
    // bus front end
    // =========================================================
    logic wr_en; // write data phase
    logic rd_en; // read data cycle
    logic [7:0] reg_addr; // word-aligned offset

    ber_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .reg_addr(reg_addr)
    );

    // =========================================================
    // software-written registers
    // =========================================================
    logic [ber_pkg::BER_CTRL_W-1:0] ctrl; // control bits
    logic [2:0] sec_unc_mask; // secondary uncorrectable mask
    logic [2:0] unc_mask; // uncorrectable mask
    logic [2:0] unc_sev; // uncorrectable severity
    logic [2:0] int_mask; // interrupt enables

    // control and mask writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= ber_pkg::BER_CTRL_RST;
            sec_unc_mask <= ber_pkg::BER_MASK3_RST;
            unc_mask <= ber_pkg::BER_MASK3_RST;
            unc_sev <= ber_pkg::BER_SEV_RST;
            int_mask <= ber_pkg::BER_MASK3_RST;
        end else if (wr_en) begin
            unique case (reg_addr)
                ber_pkg::BER_OFF_CTRL: ctrl <= hwdata[ber_pkg::BER_CTRL_W-1:0];
                ber_pkg::BER_OFF_SEC_UNC_MASK: sec_unc_mask <= hwdata[2:0];
                ber_pkg::BER_OFF_UNC_MASK: unc_mask <= hwdata[2:0];
                ber_pkg::BER_OFF_UNC_SEVERITY: unc_sev <= hwdata[2:0];
                ber_pkg::BER_OFF_INT_MASK: int_mask <= hwdata[2:0];
                default: begin
                    // other offsets hold flags or nothing
                end
            endcase
        end
    end

    logic system_error_report_enable; // system_error_report_enable
    logic ma_mode; // master_abort_mode
    logic adv_en; // advisory nonfatal enable
    logic sec_fatal; // secondary class severity
    logic [1:0] pstate; // current power state

    assign system_error_report_enable = ctrl[ber_pkg::BER_CTRL_SYSTEM_ERROR_REPORT_ENABLE];
    assign ma_mode = ctrl[ber_pkg::BER_CTRL_MA_MODE];
    assign adv_en = ctrl[ber_pkg::BER_CTRL_ADV_EN];
    assign sec_fatal = ctrl[ber_pkg::BER_CTRL_SEC_FATAL];
    assign pstate = ctrl[ber_pkg::BER_CTRL_PSTATE +: 2];

    // =========================================================
    // request classification
    // =========================================================
    logic ur_vendor; // vendor message type 0
    logic ur_pstate; // request blocked by power state
    logic ur_func; // type 0 config to nonzero function
    logic ev_ur; // any unsupported request

    assign ur_vendor = req_valid & req_is_vendor_type0; // RULE11
    assign ur_pstate = req_valid & (pstate != ber_pkg::BER_D0) & ~req_is_config & ~req_is_message; // RULE12
    assign ur_func = req_valid & req_is_config & req_cfg_type0 & (req_function != 3'h0); // RULE13
    assign ev_ur = ur_vendor | ur_pstate | ur_func;

    // =========================================================
    // pcie uncorrectable classes: log, severity, advisory
    // =========================================================
    logic [2:0] unc_ev; // per-class events
    logic [2:0] unc_adv; // handled as advisory nonfatal
    logic [2:0] unc_rep; // reported as fatal or nonfatal

    assign unc_ev[ber_pkg::BER_UN_UXC] = ev_unexpected_completion;
    assign unc_ev[ber_pkg::BER_UN_CTO] = ev_completion_timeout;
    assign unc_ev[ber_pkg::BER_UN_UR] = ev_ur;

    // per-class advisory decision, nonfatal errors only, masked or not
    genvar gi;
    generate
        for (gi = 0; gi < ber_pkg::BER_W3; gi++) begin : g_unc
            assign unc_adv[gi] = unc_ev[gi] & adv_en & ~unc_sev[gi]; // RULE9 RULE10 RULE14
            assign unc_rep[gi] = unc_ev[gi] & ~unc_mask[gi] & ~unc_adv[gi];
        end
    endgenerate

    // =========================================================
    // secondary-side classes
    // =========================================================
    logic sec_perr; // delayed read completion data error
    logic sec_rma_p; // posted write master abort
    logic sec_rta; // target abort, either kind
    logic sec_any; // any secondary error detected
    logic sec_msg; // secondary error leads to a message

    assign sec_perr = ev_read_cpl_data_err;
    assign sec_rma_p = ev_posted_wr_master_abort;
    assign sec_rta = ev_posted_target_abort | ev_nonposted_target_abort;
    assign sec_any = sec_perr | sec_rma_p | ev_nonposted_wr_master_abort | sec_rta; // RULE4 RULE5

    // message goes up for unmasked classes, posted master abort also in ma_mode; nonposted master abort always
    assign sec_msg = (sec_perr & ~sec_unc_mask[ber_pkg::BER_SU_PERR])
                   | (sec_rma_p & (~sec_unc_mask[ber_pkg::BER_SU_RMA] | ma_mode)) // RULE3
                   | ev_nonposted_wr_master_abort
                   | (sec_rta & ~sec_unc_mask[ber_pkg::BER_SU_RTA]);

    // =========================================================
    // message generation
    // =========================================================
    logic next_fatal; // fatal message this cycle
    logic next_nonfatal; // nonfatal message this cycle
    logic next_cor; // correctable message this cycle

    assign next_fatal = (sec_msg & sec_fatal) | (|(unc_rep & unc_sev));
    assign next_nonfatal = (sec_msg & ~sec_fatal) | (|(unc_rep & ~unc_sev));
    assign next_cor = |unc_adv;

    // message pulses are registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_fatal <= 1'b0;
            msg_nonfatal <= 1'b0;
            msg_correctable <= 1'b0;
        end else begin
            msg_fatal <= next_fatal;
            msg_nonfatal <= next_nonfatal;
            msg_correctable <= next_cor;
        end
    end

    // =========================================================
    // flag groups
    // =========================================================
    logic [2:0] pri_q, pri_set; // primary status
    logic [1:0] sec_q, sec_set; // secondary status
    logic [2:0] su_q, su_set; // secondary uncorrectable status
    logic [2:0] un_q, un_set; // uncorrectable status
    logic [3:0] dev_q, dev_set; // device status
    logic [31:0] w1c; // write-one-clear data
    logic pri_wr, sec_wr, su_wr, un_wr, dev_wr; // write selects

    assign w1c = hwdata;
    assign pri_wr = wr_en & (reg_addr == ber_pkg::BER_OFF_PRI_STATUS);
    assign sec_wr = wr_en & (reg_addr == ber_pkg::BER_OFF_SEC_STATUS);
    assign su_wr = wr_en & (reg_addr == ber_pkg::BER_OFF_SEC_UNC_STATUS);
    assign un_wr = wr_en & (reg_addr == ber_pkg::BER_OFF_UNC_STATUS);
    assign dev_wr = wr_en & (reg_addr == ber_pkg::BER_OFF_DEV_STATUS);

    // primary status sources
    always_comb begin
        pri_set = 3'h0;
        pri_set[ber_pkg::BER_PRI_SSE] = (next_fatal | next_nonfatal) & system_error_report_enable; // RULE2 RULE3
        pri_set[ber_pkg::BER_PRI_RMA] = ev_ur_completion; // RULE6
        pri_set[ber_pkg::BER_PRI_RTA] = ev_ca_completion; // RULE8
    end

    // secondary status sources
    always_comb begin
        sec_set = 2'h0;
        sec_set[ber_pkg::BER_SEC_STA] = (ev_ur_completion & ma_mode) | ev_ca_completion; // RULE7 RULE8
        sec_set[ber_pkg::BER_SEC_RTA] = sec_rta; // RULE5
    end

    // secondary uncorrectable status sources
    always_comb begin
        su_set = 3'h0;
        su_set[ber_pkg::BER_SU_PERR] = sec_perr; // RULE1
        su_set[ber_pkg::BER_SU_RMA] = sec_rma_p; // RULE4
        su_set[ber_pkg::BER_SU_RTA] = sec_rta; // RULE5
    end

    // uncorrectable status logs only unmasked classes
    assign un_set = unc_ev & ~unc_mask; // RULE9 RULE10 RULE11

    // device status sources
    always_comb begin
        dev_set = 4'h0;
        dev_set[ber_pkg::BER_DEV_COR] = |unc_adv; // RULE9 RULE10 RULE14
        dev_set[ber_pkg::BER_DEV_NFTL] = (sec_any & ~sec_fatal) | (|(unc_ev & ~unc_adv & ~unc_sev)); // RULE1
        dev_set[ber_pkg::BER_DEV_FTL] = (sec_any & sec_fatal) | (|(unc_ev & unc_sev)); // RULE1
        dev_set[ber_pkg::BER_DEV_URD] = ev_ur; // RULE14
    end

    ber_flags #(.W(3)) u_pri (
        .hclk(hclk), .hresetn(hresetn), .set(pri_set), .clr(w1c[2:0] & {3{pri_wr}}), .q(pri_q)
    );
    ber_flags #(.W(2)) u_sec (
        .hclk(hclk), .hresetn(hresetn), .set(sec_set), .clr(w1c[1:0] & {2{sec_wr}}), .q(sec_q)
    );
    ber_flags #(.W(3)) u_su (
        .hclk(hclk), .hresetn(hresetn), .set(su_set), .clr(w1c[2:0] & {3{su_wr}}), .q(su_q)
    );
    ber_flags #(.W(3)) u_un (
        .hclk(hclk), .hresetn(hresetn), .set(un_set), .clr(w1c[2:0] & {3{un_wr}}), .q(un_q)
    );
    ber_flags #(.W(4)) u_dev (
        .hclk(hclk), .hresetn(hresetn), .set(dev_set), .clr(w1c[3:0] & {4{dev_wr}}), .q(dev_q)
    );

    // =========================================================
    // interrupt status, cleared by a read
    // =========================================================
    logic [2:0] int_q; // sticky interrupt causes
    logic [2:0] int_set; // causes this cycle
    logic int_rd; // read of interrupt status

    assign int_set = {ev_ur, next_cor, next_fatal | next_nonfatal};
    assign int_rd = rd_en & (reg_addr == ber_pkg::BER_OFF_INT_STATUS);

    // a cause arriving with the read stays set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_q <= 3'h0;
        end else begin
            int_q <= (int_q & ~{3{int_rd}}) | int_set;
        end
    end

    // level interrupt from unmasked causes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_q & ~{3{int_rd}}) | int_set) & int_mask);
        end
    end

    // =========================================================
    // read data
    // =========================================================
    logic [31:0] next_rdata; // selected register

    // read mux, unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr)
            ber_pkg::BER_OFF_CTRL: next_rdata = {26'h0, ctrl};
            ber_pkg::BER_OFF_PRI_STATUS: next_rdata = {29'h0, pri_q};
            ber_pkg::BER_OFF_SEC_STATUS: next_rdata = {30'h0, sec_q};
            ber_pkg::BER_OFF_SEC_UNC_STATUS: next_rdata = {29'h0, su_q};
            ber_pkg::BER_OFF_SEC_UNC_MASK: next_rdata = {29'h0, sec_unc_mask};
            ber_pkg::BER_OFF_UNC_STATUS: next_rdata = {29'h0, un_q};
            ber_pkg::BER_OFF_UNC_MASK: next_rdata = {29'h0, unc_mask};
            ber_pkg::BER_OFF_UNC_SEVERITY: next_rdata = {29'h0, unc_sev};
            ber_pkg::BER_OFF_DEV_STATUS: next_rdata = {28'h0, dev_q};
            ber_pkg::BER_OFF_INT_STATUS: next_rdata = {29'h0, int_q};
            ber_pkg::BER_OFF_INT_MASK: next_rdata = {29'h0, int_mask};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // read data captured in the wait cycle, held after
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata <= next_rdata;
        end
    end
endmodule : ber_top

// *** ber_far.sv ***
`timescale 1ns/10ps
// stand-in for the link partner and secondary agents: at most one event or request per call
module ber_far (
    // clock
    input wire logic hclk,
    // event pulses, same order as the block's event ports
    output logic [8:0] ev,
    // received request fields
    output logic req_valid,
    output logic req_is_config,
    output logic req_is_message,
    output logic req_is_vendor_type0,
    output logic req_cfg_type0,
    output logic [2:0] req_function
);
    logic [3:0] kind; // config, message, vendor type 0, config type 0
    assign {req_is_config, req_is_message, req_is_vendor_type0, req_cfg_type0} = kind;
    initial {ev, req_valid, kind, req_function} = '0;
    // idx 0..8 events, 9 vendor message, 10 memory request, 11 config type 0, else idle
    task automatic fire(input int idx, input logic [2:0] fn);
        logic [3:0] k;
        k = idx == 9 ? 4'h6 : idx == 11 ? 4'h9 : 4'h0;
        if (idx < 9) begin
            ev[idx] <= 1'b1;
        end else if (idx < 12) begin
            req_valid <= 1'b1;
            kind <= k;
            req_function <= fn;
        end
        @(posedge hclk);
        ev <= '0;
        req_valid <= 1'b0;
        // released fields show the inverse
        kind <= ~k;
        req_function <= ~fn;
    endtask : fire
endmodule : ber_far

// *** ber_checker.sv ***
`timescale 1ns/10ps
// ==========================================
// bus timing and message causality watch
module ber_checker (
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq,
    input wire logic [1:0] htrans,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hrdata,
    input wire logic ev_read_cpl_data_err, ev_posted_wr_master_abort, ev_nonposted_wr_master_abort,
    input wire logic ev_posted_target_abort, ev_nonposted_target_abort, ev_ur_completion,
    input wire logic ev_ca_completion, ev_unexpected_completion, ev_completion_timeout, req_valid,
    input wire logic msg_fatal, msg_nonfatal, msg_correctable
);
    logic [9:0] evs; // every event source
    logic ev_any; // some event this cycle
    logic ev_one; // exactly one event this cycle
    logic take; // transfer accepted
    logic rd1; // read wait cycle
    logic wr1; // write data cycle
    assign evs = {ev_read_cpl_data_err, ev_posted_wr_master_abort, ev_nonposted_wr_master_abort,
        ev_posted_target_abort, ev_nonposted_target_abort, ev_ur_completion, ev_ca_completion,
        ev_unexpected_completion, ev_completion_timeout, req_valid};
    assign ev_any = |evs;
    assign ev_one = $onehot(evs);
    assign take = hsel && htrans[1] && hready && hsize == 3'h2;
    // data phase trackers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd1 <= 1'b0;
            wr1 <= 1'b0;
        end else begin
            rd1 <= take && !hwrite;
            wr1 <= take && hwrite;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (rd1 |-> s_read_wait) else $error("read wait state wrong");
    a_ready_idle: assert property (!rd1 |-> hreadyout) else $error("ready low outside read");
    a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write waited");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_held: assert property ($changed(hrdata) |-> rd1 || $past(rd1)) else $error("rdata moved");
    a_msg_cause: assert property ((msg_fatal || msg_nonfatal || msg_correctable) |-> $past(ev_any))
        else $error("message without event");
    a_one_class: assert property ($past(ev_one) |-> $onehot0({msg_fatal, msg_nonfatal, msg_correctable}))
        else $error("one event gave two classes");
    a_irq_cause: assert property ($rose(irq) |-> $past(ev_any) || $past(wr1, 2)) else $error("irq without cause");
endmodule : ber_checker
bind ber_top ber_checker i_ber_checker (.*);

// *** tb.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; $display("BAD %0t %h %h", $time, a, e); end end
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rdy = 1, rd_dp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, e;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, req_function;
    logic hreadyout, hresp, msg_fatal, msg_nonfatal, msg_correctable, irq;
    logic req_valid, req_is_config, req_is_message, req_is_vendor_type0, req_cfg_type0;
    logic [8:0] ev;
    wire hready = hreadyout;
    logic [31:0] expq[$]; // expected read data in issue order
    logic [7:0] clr_offs [5] = '{ber_pkg::BER_OFF_PRI_STATUS, ber_pkg::BER_OFF_SEC_STATUS,
        ber_pkg::BER_OFF_SEC_UNC_STATUS, ber_pkg::BER_OFF_UNC_STATUS, ber_pkg::BER_OFF_DEV_STATUS};
    int err_total = 0, total_checks = 0, cyc = 0;
    always #12.5 hclk = ~hclk;
    ber_far i_ber_far (.*);
    ber_top i_ber_top (.*, .ev_read_cpl_data_err(ev[0]), .ev_posted_wr_master_abort(ev[1]),
        .ev_nonposted_wr_master_abort(ev[2]), .ev_posted_target_abort(ev[3]),
        .ev_nonposted_target_abort(ev[4]), .ev_ur_completion(ev[5]), .ev_ca_completion(ev[6]),
        .ev_unexpected_completion(ev[7]), .ev_completion_timeout(ev[8]));
    task automatic final_report;
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // hang guard
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    // ready seen mid-cycle, clear of the edge
    always @(negedge hclk) rdy <= hreadyout;
    // read data watcher: oldest note against returned word
    always @(negedge hclk) begin
        if (rd_dp && hreadyout) begin
            e = expq.pop_front();
            `CHK(hrdata, e)
        end
    end
    // one single ahb-lite transfer, entered just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (!rdy);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp = !w;
        do @(posedge hclk); while (!rdy);
        rd_dp = 0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        expq.push_back(x);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    // configure, raise at most one event, check the five logs, then clear them
    task automatic scen(input logic [31:0] c, input int idx, input logic [31:0] p, s, u, n, d);
        logic [31:0] x [5] = '{p, s, u, n, d};
        bus(ber_pkg::BER_OFF_CTRL, 1'b1, c);
        i_ber_far.fire(idx, 3'($urandom_range(7, 1)));
        foreach (clr_offs[i]) rd(clr_offs[i], x[i]);
        foreach (clr_offs[i]) bus(clr_offs[i], 1'b1, 32'hf);
    endtask : scen
    initial begin
        void'($urandom(32'h242d));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        scen(1, 0, 1, 0, 1, 0, 2);
        scen(1, 1, 1, 0, 2, 0, 2);
        scen(1, 2, 1, 0, 0, 0, 2);
        scen(1, 3, 1, 2, 4, 0, 2);
        scen(32'h21, 4, 1, 2, 4, 0, 4);
        scen(0, 5, 2, 0, 0, 0, 0);
        scen(2, 5, 2, 1, 0, 0, 0);
        scen(0, 6, 4, 1, 0, 0, 0);
        scen(1, 7, 1, 0, 0, 1, 2);
        scen(4, 7, 0, 0, 0, 1, 1);
        scen(1, 8, 1, 0, 0, 2, 2);
        scen(4, 8, 0, 0, 0, 2, 1);
        scen(0, 9, 0, 0, 0, 4, 32'ha);
        scen(8, 10, 0, 0, 0, 4, 32'ha);
        scen(4, 11, 0, 0, 0, 4, 9);
        scen(0, 15, 0, 0, 0, 0, 0);
        bus(ber_pkg::BER_OFF_SEC_UNC_MASK, 1'b1, 32'h2);
        scen(1, 1, 0, 0, 2, 0, 2);
        scen(3, 1, 1, 0, 2, 0, 2);
        bus(ber_pkg::BER_OFF_UNC_MASK, 1'b1, 32'h2);
        scen(1, 8, 0, 0, 0, 0, 2);
        e = $urandom;
        bus(ber_pkg::BER_OFF_UNC_SEVERITY, 1'b1, e);
        rd(ber_pkg::BER_OFF_UNC_SEVERITY, e & 32'h7);
        bus(ber_pkg::BER_OFF_UNC_SEVERITY, 1'b1, 32'h0);
        bus(ber_pkg::BER_OFF_UNC_MASK, 1'b1, 32'h0);
        rd(8'h40, 0);
        rd(ber_pkg::BER_OFF_INT_STATUS, 7);
        bus(ber_pkg::BER_OFF_INT_MASK, 1'b1, 32'h1);
        i_ber_far.fire(8, 3'h0);
        repeat (3) @(negedge hclk);
        `CHK(irq, 1'b1)
        @(posedge hclk);
        rd(ber_pkg::BER_OFF_INT_STATUS, 1);
        rd(ber_pkg::BER_OFF_INT_STATUS, 0);
        @(negedge hclk);
        `CHK(irq, 1'b0)
        @(posedge hclk);
        bus(ber_pkg::BER_OFF_INT_MASK, 1'b1, 32'h0);
        i_ber_far.fire(8, 3'h0);
        repeat (3) @(negedge hclk);
        `CHK(irq, 1'b0)
        @(posedge hclk);
        rd(ber_pkg::BER_OFF_INT_STATUS, 1);
        final_report();
    end
endmodule : tb
